// file: hdl/pias_pkg.sv
// package: register map, field layout and carriers of the indirect access bank
// Overview of operation
// - command 0 selects address mode, 1 plain data, no increment
// - command 2 advances pointer after reads and writes, 3 after writes
// - target space field routes every later data port access to that space when the code is a supported one
// - all-ones target code selects vendor space, registers up to 0x04D1
// - code 00011 selects third space, code 00111 selects seventh space
// - data port accesses with an unsupported target code change nothing
// - data port is the space's address pointer in mode 00, else its data
// - each link drop cause bit latches high when its condition drops link
// - cause codes: energy 0x1, snr 0x2, line code 0x4, rx 0x8, sync 0x10
// - status bit 14 is 0 for normal pairs, 1 for swapped pairs
// - status bit 13 sets on receive error, clears on error counter read
// - status bit 12 mirrors polarity flag, clears on 0x001A read only
// - status bit 11 sets on false carrier, clears on 0x0014 read
// - status bit 10 shows 100 Mbps signal detect, active high
// - status bit 9 shows 100 Mbps descrambler lock, active high
// - status bit 7 shows pending interrupt, interrupt status read clears it
// - bit 2: 0 half, 1 full duplex; bit 1: 0 is 100, 1 is 10 Mbps
// - status bit 0 copies link status; status register read leaves it alone
// - status bit 4 is 1 once auto negotiation has completed
package pias_pkg;

  // register offsets on the management bus
  localparam logic [4:0]  REG_INDIRECT_CTRL   = 5'h0D;
  localparam logic [4:0]  REG_INDIRECT_DATA   = 5'h0E;
  localparam logic [4:0]  REG_LINK_DROP       = 5'h0F;
  localparam logic [4:0]  REG_PHY_STATUS      = 5'h10;
  localparam logic [4:0]  REG_INT_STATUS      = 5'h12;
  localparam logic [4:0]  REG_FALSE_CARR_CNT  = 5'h14;
  localparam logic [4:0]  REG_RX_ERR_CNT      = 5'h15;
  localparam logic [4:0]  REG_TEN_STATUS      = 5'h1A;

  // reset values
  localparam logic [15:0] RST_INDIRECT_CTRL   = 16'h0000;
  localparam logic [15:0] RST_INDIRECT_DATA   = 16'h0000;

  // indirect control fields and codes
  localparam int          CMD_MSB             = 15;
  localparam int          CMD_LSB             = 14;
  localparam int          SPACE_MSB           = 4;
  localparam logic [1:0]  CMD_ADDRESS         = 2'h0;
  localparam logic [1:0]  CMD_DATA            = 2'h1;
  localparam logic [1:0]  CMD_DATA_INC_RW     = 2'h2;
  localparam logic [1:0]  CMD_DATA_INC_WR     = 2'h3;
  localparam logic [4:0]  SPACE_VENDOR        = 5'h1F;
  localparam logic [4:0]  SPACE_THIRD         = 5'h03;
  localparam logic [4:0]  SPACE_SEVENTH       = 5'h07;
  localparam logic [15:0] VENDOR_ADDR_MAX     = 16'h04D1;

  // link drop cause field
  localparam int          DROP_LSB            = 4;
  localparam logic [4:0]  DROP_ENERGY         = 5'h01;
  localparam logic [4:0]  DROP_SNR            = 5'h02;
  localparam logic [4:0]  DROP_LINE_CODE      = 5'h04;
  localparam logic [4:0]  DROP_RX_ERR         = 5'h08;
  localparam logic [4:0]  DROP_SYNC_LOSS      = 5'h10;

  // status register bit positions
  localparam int          ST_MDIX             = 14;
  localparam int          ST_RX_ERR           = 13;
  localparam int          ST_POLARITY         = 12;
  localparam int          ST_FALSE_CARR       = 11;
  localparam int          ST_SIG_DETECT       = 10;
  localparam int          ST_DESCR_LOCK       = 9;
  localparam int          ST_INT_PEND         = 7;
  localparam int          ST_AN_DONE          = 4;
  localparam int          ST_DUPLEX           = 2;
  localparam int          ST_SPEED_10         = 1;
  localparam int          ST_LINK             = 0;

  // sticky flag vector layout
  localparam int          STK_WIDTH           = 9;
  localparam int          STK_RX_ERR          = 0;
  localparam int          STK_POLARITY        = 1;
  localparam int          STK_FALSE_CARR      = 2;
  localparam int          STK_INT_PEND        = 3;
  localparam int          STK_DROP_LSB        = 4;

  // management frame layout
  localparam logic [5:0]  PREAMBLE_LEN        = 6'd32;
  localparam logic [4:0]  HDR_BITS            = 5'd14;
  localparam logic [4:0]  DATA_BITS           = 5'd16;
  localparam logic [1:0]  FRAME_START         = 2'b01;
  localparam logic [1:0]  OP_READ             = 2'b10;
  localparam logic [1:0]  OP_WRITE            = 2'b01;

  // frame engine states
  typedef enum logic [2:0] {
    MS_PRE,
    MS_HDR,
    MS_TA,
    MS_RD,
    MS_WR
  } pias_mdio_e;

  // condition inputs from the receive and negotiation logic
  typedef struct packed {
    logic       mdix_swapped;
    logic       signal_detect;
    logic       descr_lock;
    logic       an_complete;
    logic       full_duplex;
    logic       speed_10;
    logic       link_up;
    logic       rx_err_event;
    logic       false_carr_event;
    logic       polarity_event;
    logic       int_event;
    logic [4:0] drop_cause;
  } pias_phy_stat_s;

  // request to the extended register spaces
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pias_ext_req_s;

endpackage

// file: hdl/pias_sticky.sv
// sticky flag bank: hardware sets, read side effects clear
`timescale 1ns/1ps
`default_nettype none
module pias_sticky #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] next_q;

  // a set in the clearing cycle survives the clear
  always_comb begin
    next_q = (q & ~clr) | set;
  end

  // flag storage
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule // pias_sticky
`default_nettype wire

// file: hdl/pias_regs.sv
// indirect access and condition status registers behind the management port
`timescale 1ns/1ps
`default_nettype none
module pias_regs (
  input  wire logic                    REF_CLK,
  input  wire logic                    RST,
  input  wire logic [4:0]              PHY_ADDR,
  input  wire logic                    MDC,
  input  wire logic                    MDIO_I,
  output logic                         MDIO_O,
  output logic                         MDIO_OE,
  input  wire pias_pkg::pias_phy_stat_s PHY_STAT,
  output pias_pkg::pias_ext_req_s      EXT_REQ,
  input  wire logic [15:0]             EXT_RDATA
);

  // true for the three spaces that the data port may reach
  function automatic logic space_ok(input logic [4:0] code);
    space_ok = (code == pias_pkg::SPACE_VENDOR) ||
               (code == pias_pkg::SPACE_THIRD)  ||
               (code == pias_pkg::SPACE_SEVENTH);
  endfunction

  // pointer slot of a supported space
  function automatic logic [1:0] space_idx(input logic [4:0] code);
    if (code == pias_pkg::SPACE_THIRD) begin
      space_idx = 2'h1;
    end else if (code == pias_pkg::SPACE_SEVENTH) begin
      space_idx = 2'h2;
    end else begin
      space_idx = 2'h0;
    end
  endfunction

  // pin synchronisers
  logic                    mdc_s1;
  logic                    mdc_s2;
  logic                    mdc_s3;
  logic                    mdio_s1;
  logic                    mdio_s2;
  logic                    mdc_rise;
  logic                    mdio_bit;

  // frame engine
  pias_pkg::pias_mdio_e    state;
  pias_pkg::pias_mdio_e    next_state;
  logic [5:0]              ones;
  logic [5:0]              next_ones;
  logic [4:0]              cnt;
  logic [4:0]              next_cnt;
  logic [15:0]             shift;
  logic [15:0]             next_shift;
  logic [4:0]              regad;
  logic [4:0]              next_regad;
  logic                    is_read;
  logic                    next_is_read;
  logic                    mdio_out;
  logic                    next_mdio_out;
  logic                    mdio_oe;
  logic                    next_mdio_oe;

  // register contents
  logic [1:0]              cmd;
  logic [1:0]              next_cmd;
  logic [4:0]              space;
  logic [4:0]              next_space;
  logic [15:0]             ptr [3];
  logic [15:0]             next_ptr [3];
  pias_pkg::pias_ext_req_s ext;
  pias_pkg::pias_ext_req_s next_ext;

  // sticky flags
  logic [pias_pkg::STK_WIDTH-1:0] stk_set;
  logic [pias_pkg::STK_WIDTH-1:0] stk_clr;
  logic [pias_pkg::STK_WIDTH-1:0] stk_q;

  // read path
  logic [15:0]             rd_value;
  logic [15:0]             status_word;
  logic [15:0]             drop_word;
  logic [13:0]             hdr;
  logic [15:0]             wword;
  logic [1:0]              cur_idx;
  logic                    cur_ok;

  // two flops on each pin before anything looks at it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mdc_s1  <= 1'b0;
      mdc_s2  <= 1'b0;
      mdc_s3  <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1  <= MDC;
      mdc_s2  <= mdc_s1;
      mdc_s3  <= mdc_s2;
      mdio_s1 <= MDIO_I;
      mdio_s2 <= mdio_s1;
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_s3;
  assign mdio_bit = mdio_s2;

  // set sources of the sticky flags
  always_comb begin
    stk_set = '0;
    stk_set[pias_pkg::STK_RX_ERR]     = PHY_STAT.rx_err_event;
    stk_set[pias_pkg::STK_POLARITY]   = PHY_STAT.polarity_event;
    stk_set[pias_pkg::STK_FALSE_CARR] = PHY_STAT.false_carr_event;
    stk_set[pias_pkg::STK_INT_PEND]   = PHY_STAT.int_event;
    stk_set[pias_pkg::STK_DROP_LSB +: 5] = PHY_STAT.drop_cause;
  end

  pias_sticky #(
    .WIDTH (pias_pkg::STK_WIDTH)
  ) u_sticky (
    .clk   (REF_CLK),
    .rst   (RST),
    .set   (stk_set),
    .clr   (stk_clr),
    .q     (stk_q)
  );

  // selected space of the current control setting
  assign cur_ok  = space_ok(space);
  assign cur_idx = space_idx(space);

  // condition status and link drop words, reserved bits zero
  always_comb begin
    status_word = '0;
    status_word[pias_pkg::ST_MDIX]       = PHY_STAT.mdix_swapped;
    status_word[pias_pkg::ST_RX_ERR]     = stk_q[pias_pkg::STK_RX_ERR];
    status_word[pias_pkg::ST_POLARITY]   =
      stk_q[pias_pkg::STK_POLARITY];
    status_word[pias_pkg::ST_FALSE_CARR] =
      stk_q[pias_pkg::STK_FALSE_CARR];
    status_word[pias_pkg::ST_SIG_DETECT] = PHY_STAT.signal_detect;
    status_word[pias_pkg::ST_DESCR_LOCK] = PHY_STAT.descr_lock;
    status_word[pias_pkg::ST_INT_PEND]   =
      stk_q[pias_pkg::STK_INT_PEND];
    status_word[pias_pkg::ST_AN_DONE]    = PHY_STAT.an_complete;
    status_word[pias_pkg::ST_DUPLEX]     = PHY_STAT.full_duplex;
    status_word[pias_pkg::ST_SPEED_10]   = PHY_STAT.speed_10;
    status_word[pias_pkg::ST_LINK]       = PHY_STAT.link_up;
    drop_word = '0;
    drop_word[pias_pkg::DROP_LSB +: 5] =
      stk_q[pias_pkg::STK_DROP_LSB +: 5];
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_value = '0;
    unique case (regad)
      pias_pkg::REG_INDIRECT_CTRL: begin
        rd_value[pias_pkg::CMD_MSB:pias_pkg::CMD_LSB] = cmd;
        rd_value[pias_pkg::SPACE_MSB:0]               = space;
      end
      pias_pkg::REG_INDIRECT_DATA: begin
        if (!cur_ok) begin
          rd_value = '0;
        end else if (cmd == pias_pkg::CMD_ADDRESS) begin
          rd_value = ptr[cur_idx];
        end else begin
          rd_value = EXT_RDATA;
        end
      end
      pias_pkg::REG_LINK_DROP:  rd_value = drop_word;
      pias_pkg::REG_PHY_STATUS: rd_value = status_word;
      default:                  rd_value = '0;
    endcase
  end

  assign hdr   = {shift[12:0], mdio_bit};
  assign wword = {shift[14:0], mdio_bit};

  // frame engine and register updates, all advanced on a rising MDC
  always_comb begin
    next_state    = state;
    next_ones     = ones;
    next_cnt      = cnt;
    next_shift    = shift;
    next_regad    = regad;
    next_is_read  = is_read;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    next_cmd      = cmd;
    next_space    = space;
    next_ptr      = ptr;
    next_ext      = ext;
    next_ext.rd   = 1'b0;
    next_ext.wr   = 1'b0;
    stk_clr       = '0;
    if (mdc_rise) begin
      unique case (state)
        pias_pkg::MS_PRE: begin
          if (mdio_bit) begin
            if (ones != pias_pkg::PREAMBLE_LEN) begin
              next_ones = ones + 6'd1;
            end
          end else if (ones == pias_pkg::PREAMBLE_LEN) begin
            next_state = pias_pkg::MS_HDR;
            next_cnt   = 5'd1;
            next_shift = 16'h0000;
          end else begin
            next_ones = 6'd0;
          end
        end
        pias_pkg::MS_HDR: begin
          next_shift = {shift[14:0], mdio_bit};
          next_cnt   = cnt + 5'd1;
          if (cnt == pias_pkg::HDR_BITS - 5'd1) begin
            next_cnt     = 5'd0;
            next_regad   = hdr[4:0];
            next_is_read = (hdr[11:10] == pias_pkg::OP_READ);
            if (hdr[13:12] == pias_pkg::FRAME_START &&
                (hdr[11:10] == pias_pkg::OP_READ ||
                 hdr[11:10] == pias_pkg::OP_WRITE) &&
                hdr[9:5] == PHY_ADDR) begin
              next_state = pias_pkg::MS_TA;
              // fetch early so the space has the turnaround to answer
              if (hdr[11:10] == pias_pkg::OP_READ &&
                  hdr[4:0] == pias_pkg::REG_INDIRECT_DATA &&
                  cur_ok && cmd != pias_pkg::CMD_ADDRESS) begin
                next_ext.rd    = 1'b1;
                next_ext.space = space;
                next_ext.addr  = ptr[cur_idx];
              end
            end else begin
              next_state = pias_pkg::MS_PRE;
              next_ones  = 6'd0;
            end
          end
        end
        pias_pkg::MS_TA: begin
          if (is_read) begin
            // second turnaround bit driven low, data captured now
            next_mdio_oe  = 1'b1;
            next_mdio_out = 1'b0;
            next_shift    = rd_value;
            next_cnt      = 5'd0;
            next_state    = pias_pkg::MS_RD;
            unique case (regad)
              pias_pkg::REG_RX_ERR_CNT:
                stk_clr[pias_pkg::STK_RX_ERR] = 1'b1;
              pias_pkg::REG_TEN_STATUS:
                stk_clr[pias_pkg::STK_POLARITY] = 1'b1;
              pias_pkg::REG_FALSE_CARR_CNT:
                stk_clr[pias_pkg::STK_FALSE_CARR] = 1'b1;
              pias_pkg::REG_INT_STATUS:
                stk_clr[pias_pkg::STK_INT_PEND] = 1'b1;
              pias_pkg::REG_LINK_DROP:
                stk_clr[pias_pkg::STK_DROP_LSB +: 5] = 5'h1F;
              pias_pkg::REG_INDIRECT_DATA: begin
                if (cur_ok && cmd == pias_pkg::CMD_DATA_INC_RW) begin
                  next_ptr[cur_idx] = ptr[cur_idx] + 16'h0001;
                end
              end
              default: begin
              end
            endcase
          end else if (cnt == 5'd0) begin
            next_cnt = 5'd1;
          end else begin
            next_cnt   = 5'd0;
            next_state = pias_pkg::MS_WR;
          end
        end
        pias_pkg::MS_RD: begin
          if (cnt != pias_pkg::DATA_BITS) begin
            next_mdio_out = shift[15];
            next_shift    = {shift[14:0], 1'b0};
            next_cnt      = cnt + 5'd1;
          end else begin
            next_mdio_oe  = 1'b0;
            next_mdio_out = 1'b0;
            next_state    = pias_pkg::MS_PRE;
            next_ones     = 6'd0;
          end
        end
        pias_pkg::MS_WR: begin
          next_shift = wword;
          next_cnt   = cnt + 5'd1;
          if (cnt == pias_pkg::DATA_BITS - 5'd1) begin
            next_state = pias_pkg::MS_PRE;
            next_ones  = 6'd0;
            if (regad == pias_pkg::REG_INDIRECT_CTRL) begin
              // reserved bits 13..5 are dropped
              next_cmd   = wword[pias_pkg::CMD_MSB:pias_pkg::CMD_LSB];
              next_space = wword[pias_pkg::SPACE_MSB:0];
            end else if (regad == pias_pkg::REG_INDIRECT_DATA && cur_ok) begin
              if (cmd == pias_pkg::CMD_ADDRESS) begin
                next_ptr[cur_idx] = wword;
              end else begin
                next_ext.wr    = 1'b1;
                next_ext.space = space;
                next_ext.addr  = ptr[cur_idx];
                next_ext.wdata = wword;
                if (cmd == pias_pkg::CMD_DATA_INC_RW ||
                    cmd == pias_pkg::CMD_DATA_INC_WR) begin
                  next_ptr[cur_idx] = ptr[cur_idx] + 16'h0001;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // state and register storage
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state    <= pias_pkg::MS_PRE;
      ones     <= 6'd0;
      cnt      <= 5'd0;
      shift    <= 16'h0000;
      regad    <= 5'h00;
      is_read  <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      cmd      <=
        pias_pkg::RST_INDIRECT_CTRL[pias_pkg::CMD_MSB:pias_pkg::CMD_LSB];
      space    <= pias_pkg::RST_INDIRECT_CTRL[pias_pkg::SPACE_MSB:0];
      ptr[0]   <= pias_pkg::RST_INDIRECT_DATA;
      ptr[1]   <= pias_pkg::RST_INDIRECT_DATA;
      ptr[2]   <= pias_pkg::RST_INDIRECT_DATA;
      ext      <= '0;
    end else begin
      state    <= next_state;
      ones     <= next_ones;
      cnt      <= next_cnt;
      shift    <= next_shift;
      regad    <= next_regad;
      is_read  <= next_is_read;
      mdio_out <= next_mdio_out;
      mdio_oe  <= next_mdio_oe;
      cmd      <= next_cmd;
      space    <= next_space;
      ptr      <= next_ptr;
      ext      <= next_ext;
    end
  end

  // pin and space request outputs
  assign MDIO_O  = mdio_out;
  assign MDIO_OE = mdio_oe;
  assign EXT_REQ = ext;

endmodule // pias_regs
`default_nettype wire

// file: tb/pias_regs_props.sv
// checker: port timing relations of the indirect access register bank
`timescale 1ns/1ps
`default_nettype none
module pias_regs_props (
  input  wire logic                     REF_CLK,
  input  wire logic                     RST,
  input  wire logic [4:0]               PHY_ADDR,
  input  wire logic                     MDC,
  input  wire logic                     MDIO_I,
  input  wire logic                     MDIO_O,
  input  wire logic                     MDIO_OE,
  input  wire pias_pkg::pias_phy_stat_s PHY_STAT,
  input  wire pias_pkg::pias_ext_req_s  EXT_REQ,
  input  wire logic [15:0]              EXT_RDATA
);
  logic       mdc_d;
  logic [4:0] rise_cnt;
  logic [4:0] next_rise_cnt;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // count mdc rises seen while the device drives the pin
  always_comb begin
    next_rise_cnt = MDIO_OE ? rise_cnt + {4'h0, MDC & ~mdc_d} : 5'h00;
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rise_cnt <= 5'h00;
      mdc_d    <= 1'b0;
    end else begin
      rise_cnt <= next_rise_cnt;
      mdc_d    <= MDC;
    end
  end
  // a data port read request is followed by the turnaround drive
  sequence s_rd_req;
    $rose(EXT_REQ.rd);
  endsequence
  sequence s_drive;
    ##[1:24] $rose(MDIO_OE);
  endsequence
  // reset clears the request and releases the pin
  property p_reset_quiet;
    @(posedge REF_CLK) disable iff (1'b0)
      RST |=> (EXT_REQ == '0) && !MDIO_OE;
  endproperty
  reset_quiet_a: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
  rd_then_drive_a: assert property (s_rd_req |-> s_drive)
    else $error("read request without data drive");
  space_legal_a: assert property (
      (EXT_REQ.rd || EXT_REQ.wr) |->
      EXT_REQ.space inside {5'h1F, 5'h03, 5'h07})
    else $error("request to unsupported space");
  req_exclusive_a: assert property (!(EXT_REQ.rd && EXT_REQ.wr))
    else $error("read and write together");
  wr_pulse_one_a: assert property (EXT_REQ.wr |=> !EXT_REQ.wr)
    else $error("write pulse longer than a cycle");
  rd_pulse_one_a: assert property (EXT_REQ.rd |=> !EXT_REQ.rd)
    else $error("read pulse longer than a cycle");
  wr_idle_pin_a: assert property (EXT_REQ.wr |-> !MDIO_OE)
    else $error("write commit while driving pin");
  oe_quiet_out_a: assert property (!MDIO_OE |-> !MDIO_O)
    else $error("data out while not driving");
  oe_span_a: assert property ($fell(MDIO_OE) |-> rise_cnt == 5'd17)
    else $error("drive window not 17 mdc rises");
  hold_fields_a: assert property (!(EXT_REQ.rd || EXT_REQ.wr) |->
      $stable(EXT_REQ.space) && $stable(EXT_REQ.addr))
    else $error("request fields moved without a request");
endmodule // pias_regs_props
`default_nettype wire

// file: tb/pias_sta.sv
// partner model: station management controller sending frames
`timescale 1ns/1ps
`default_nettype none
module pias_sta (
  input  wire logic ref_clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      mdo,
  output logic      mdo_en
);
  // clock stands low and the pin is released outside frames
  initial begin
    mdc    = 1'b0;
    mdo    = 1'b0;
    mdo_en = 1'b0;
  end
  // one frame of 64 bits, eight clocks each, data changes while mdc low
  task automatic xfer(input logic rd, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] q);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
    q = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge ref_clk);
      mdc    <= 1'b0;
      mdo    <= f[i];
      mdo_en <= !(rd && i < 18); // released from turnaround on in reads
      repeat (4) @(posedge ref_clk);
      mdc <= 1'b1;
      if (rd && i < 16) q[i] = mdio; // data sampled at the rising mdc
      repeat (3) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    mdc    <= 1'b0;
    mdo_en <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // pias_sta
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the indirect access and status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (b)); \
  end \
end
module testbench;
  typedef struct packed {
    logic        w;
    logic [4:0]  ra;
    logic [15:0] d;
    logic [15:0] e;
    logic [36:0] q;
  } pias_row_s;
  localparam logic [4:0] PHY = 5'h05;
  logic                     REF_CLK = 1'b0;
  logic                     RST = 1'b1;
  logic                     mdc;
  logic                     mdo;
  logic                     mdo_en;
  logic                     mdio_o;
  logic                     mdio_oe;
  logic                     mdio;
  pias_pkg::pias_phy_stat_s ps = '0;
  pias_pkg::pias_ext_req_s  ext_req;
  logic [15:0]              ext_rdata = 16'h0000;
  logic [36:0]              last_req = 37'h0;
  logic [15:0]              q;
  logic [4:0]               clr_reg [4] = '{5'h15, 5'h1A, 5'h14, 5'h12};
  logic [15:0]              clr_exp [4];
  int                       failures = 0;
  int                       n_compared = 0;
  int                       cyc = 0;
  pias_row_s                rows [26];
  // clock and released line held high by the pull-up
  always #25 REF_CLK = ~REF_CLK;
  assign mdio = mdio_oe ? mdio_o : (mdo_en ? mdo : 1'b1);
  pias_sta sta (.ref_clk(REF_CLK), .mdio(mdio), .mdc(mdc), .mdo(mdo),
                .mdo_en(mdo_en));
  pias_regs dut (.REF_CLK(REF_CLK), .RST(RST), .PHY_ADDR(PHY), .MDC(mdc),
                 .MDIO_I(mdio), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe),
                 .PHY_STAT(ps), .EXT_REQ(ext_req), .EXT_RDATA(ext_rdata));
  function automatic logic [15:0] ext_val(input logic [4:0] s,
                                          input logic [15:0] a);
    return a ^ {s, 11'h000};
  endfunction
  // extended space model and capture of the last request
  always @(posedge REF_CLK) begin
    ext_rdata <= ext_val(ext_req.space, ext_req.addr);
    if (ext_req.rd || ext_req.wr)
      last_req[36:16] <= {ext_req.space, ext_req.addr};
    if (ext_req.wr) last_req[15:0] <= ext_req.wdata;
  end
  // hang guard
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  task automatic rd(input logic [4:0] ra);
    sta.xfer(1'b1, PHY, ra, 16'h0000, q);
  endtask
  task automatic set_stat(input logic [6:0] l, input logic [8:0] ev);
    @(posedge REF_CLK);
    ps <= {l, ev};
    @(posedge REF_CLK);
    ps <= {l, 9'h000};
  endtask
  task results();
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // table walk, then refused frame and status flags by hand
  initial begin
    clr_exp = '{16'h1C92, 16'h0C92, 16'h0492, 16'h0412};
    rows = '{'{1'b0, 5'h0D, 16'h0000, 16'h0000, 37'h0},
      '{1'b1, 5'h0D, 16'h001F, 16'h0000, 37'h0},
      '{1'b1, 5'h0E, 16'h0100, 16'h0000, 37'h0},
      '{1'b0, 5'h0E, 16'h0000, 16'h0100, 37'h0},
      '{1'b1, 5'h0D, 16'h401F, 16'h0000, 37'h0},
      '{1'b1, 5'h0E, 16'hAAAA, 16'h0000, 37'h1F0100AAAA},
      '{1'b0, 5'h0E, 16'h0000, 16'hF900, 37'h1F0100AAAA},
      '{1'b0, 5'h0E, 16'h0000, 16'hF900, 37'h1F0100AAAA},
      '{1'b1, 5'h0D, 16'h0003, 16'h0000, 37'h1F0100AAAA},
      '{1'b1, 5'h0E, 16'h0010, 16'h0000, 37'h1F0100AAAA},
      '{1'b1, 5'h0D, 16'h8003, 16'h0000, 37'h1F0100AAAA},
      '{1'b0, 5'h0E, 16'h0000, 16'h1810, 37'h030010AAAA},
      '{1'b1, 5'h0E, 16'h5555, 16'h0000, 37'h0300115555},
      '{1'b0, 5'h0E, 16'h0000, 16'h1812, 37'h0300125555},
      '{1'b1, 5'h0D, 16'hC007, 16'h0000, 37'h0300125555},
      '{1'b0, 5'h0E, 16'h0000, 16'h3800, 37'h0700005555},
      '{1'b1, 5'h0E, 16'h1111, 16'h0000, 37'h0700001111},
      '{1'b0, 5'h0E, 16'h0000, 16'h3801, 37'h0700011111},
      '{1'b1, 5'h0D, 16'h4005, 16'h0000, 37'h0700011111},
      '{1'b1, 5'h0E, 16'h7777, 16'h0000, 37'h0700011111},
      '{1'b0, 5'h0E, 16'h0000, 16'h0000, 37'h0700011111},
      '{1'b1, 5'h0D, 16'hFFE3, 16'h0000, 37'h0700011111},
      '{1'b0, 5'h0D, 16'h0000, 16'hC003, 37'h0700011111},
      '{1'b1, 5'h0D, 16'h0003, 16'h0000, 37'h0700011111},
      '{1'b0, 5'h0E, 16'h0000, 16'h0013, 37'h0700011111},
      '{1'b0, 5'h05, 16'h0000, 16'h0000, 37'h0700011111}};
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    foreach (rows[i]) begin
      sta.xfer(!rows[i].w, PHY, rows[i].ra, rows[i].d, q);
      if (!rows[i].w) `CHK(q, rows[i].e)
      `CHK(last_req, rows[i].q)
    end
    sta.xfer(1'b0, PHY ^ 5'h01, 5'h0D, 16'h401F, q);
    rd(5'h0D);
    `CHK(q, 16'h0003)
    set_stat(7'b1010101, 9'h000);
    rd(5'h10);
    `CHK(q, 16'h4205)
    set_stat(7'b0101010, 9'h1E0);
    rd(5'h10);
    `CHK(q, 16'h3C92)
    rd(5'h10);
    `CHK(q, 16'h3C92)
    for (int i = 0; i < 4; i++) begin
      rd(clr_reg[i]);
      rd(5'h10);
      `CHK(q, clr_exp[i])
    end
    for (int i = 0; i < 5; i++) begin
      set_stat(7'b0101010, {4'h0, 5'h01 << i});
      rd(5'h0F);
      `CHK(q, {7'h00, 5'h01 << i, 4'h0})
    end
    rd(5'h0F);
    `CHK(q, 16'h0000)
    // mid-run reset returns the control word to zero
    @(posedge REF_CLK);
    RST <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    rd(5'h0D);
    `CHK(q, 16'h0000)
    results();
  end
endmodule // testbench
bind pias_regs pias_regs_props u_props (
  .REF_CLK(REF_CLK), .RST(RST), .PHY_ADDR(PHY_ADDR), .MDC(MDC),
  .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE),
  .PHY_STAT(PHY_STAT), .EXT_REQ(EXT_REQ), .EXT_RDATA(EXT_RDATA));
`default_nettype wire
